// ### rtl/shz_pkg.sv
// Purpose: shared constants for the software high-impedance control block
// Assumes: registers sit in the low byte of 32-bit wishbone words
// Notes:   offsets are byte addresses of aligned words
package shz_pkg;

    // register bus geometry
    localparam int          SHZ_ADR_W     = 4;
    localparam int          SHZ_DAT_W     = 32;
    localparam int          SHZ_PIN_N     = 4;

    // register byte offsets
    localparam logic [3:0]  SHZ_SWREQ_OFS = 4'h0;
    localparam logic [3:0]  SHZ_PINEN_OFS = 4'h4;
    localparam logic [3:0]  SHZ_FLAG_OFS  = 4'h8;

    // field positions
    localparam int          SHZ_CH34_BIT  = 0;
    localparam int          SHZ_CH0_BIT   = 1;
    localparam int          SHZ_RSV_BIT   = 2;
    localparam int          SHZ_FLAG_BIT  = 0;

    // values after reset
    localparam logic        SHZ_REQ_RST   = 1'h0;
    localparam logic [3:0]  SHZ_PINEN_RST = 4'h0;
    localparam logic [3:0]  SHZ_LOCK_RST  = 4'h0;
    localparam logic        SHZ_FLAG_RST  = 1'h0;
    localparam logic        SHZ_PIN_IDLE  = 1'h1;

endpackage : shz_pkg

// ### rtl/shz_gate_if.sv
// Purpose: carries request sources and pin enables to the pin gate
// Assumes: one clock domain, plain combinational wires
// Notes:   ctrl side owns the sources, gate side returns the per-pin result
`timescale 1ns/10ps
interface shz_gate_if;
    import shz_pkg::*;
    logic                 flag;  // external request flag
    logic                 ch0;   // channel-0 software request
    logic [SHZ_PIN_N-1:0] en;    // per-pin high-impedance enables
    logic [SHZ_PIN_N-1:0] hiz;   // per-pin high-impedance request
    modport ctrl (output flag, output ch0, output en, input hiz);
    modport gate (input flag, input ch0, input en, output hiz);
endinterface : shz_gate_if

// ### rtl/shz_pin_gate.sv
// Purpose: per-pin high-impedance request from flag, software bit, enable
// Assumes: sources are register outputs in the same clock domain
// Notes:   purely combinational; the top registers the result for the pins
`timescale 1ns/10ps
module shz_pin_gate
    import shz_pkg::*;
(
    shz_gate_if.gate gi
);

    // either source qualifies every enabled pin alike
    wire any_src = gi.flag | gi.ch0;

    // one gate per pin: enable masks the shared request
    genvar i;
    generate
        for (i = 0; i < SHZ_PIN_N; i++) begin : g_pin
            assign gi.hiz[i] = gi.en[i] & any_src;
        end
    endgenerate

endmodule : shz_pin_gate

// ### rtl/shz_top.sv
// Purpose: software high-impedance requests and write-once pin enables
// Assumes: classic wishbone slave, synchronous inputs, 50 MHz clock
// Notes:   pin outputs lag register changes by one clock (registered pins)
// Contract
// - software request register eight bits, resets zero
// - upper unused bits read zero, write zero
// - request bit 2 writable yet reads zero
// - channel-0 bit one requests channel-0 high impedance
// - writing one sets channel-0 request bit
// - channel-0 bit clears on reset or read-then-write-zero
// - channel 3/4 bit one requests high-current high impedance
// - writing one sets channel 3/4 request bit
// - channel 3/4 bit clears on reset or read-then-write-zero
// - pin enable register eight bits, resets zero
// - enable 3 floats pin d on request
// - enable 2 floats pin c on request
// - enable 1 floats pin b on request
// - enable 0 floats pin a on request
// - each pin enable accepts one write only
// - external flag sets on input falling edge
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module shz_top
    import shz_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [SHZ_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [SHZ_DAT_W-1:0] wb_dat_i,
    output logic      [SHZ_DAT_W-1:0] wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 ext_hiz_req_n_i,
    input  wire logic [SHZ_PIN_N-1:0] timer_out_i,
    output logic      [SHZ_PIN_N-1:0] timer_pin_o,
    output logic      [SHZ_PIN_N-1:0] timer_pin_oe_o,
    output logic                      chan0_hiz_o,
    output logic                      chan34_hiz_o,
    output logic                      ext_flag_o
);

    // address decode shared by every register
    function automatic logic adr_hit(input logic [SHZ_ADR_W-1:0] adr,
                                     input logic [SHZ_ADR_W-1:0] ofs);
        adr_hit = (adr == ofs);
    endfunction : adr_hit

    // bus state
    logic                 ack_reg;       // answer, high for one cycle
    logic [SHZ_DAT_W-1:0] dat_reg;       // read data held with the answer

    // software request bits and their read-as-one arming
    logic                 ch0_reg;       // channel-0 request
    logic                 ch34_reg;      // channel 3/4 request
    logic                 ch0_seen_reg;  // ch0 was read as one
    logic                 ch34_seen_reg; // ch34 was read as one

    // pin enables and their write-once locks
    logic [SHZ_PIN_N-1:0] en_reg;        // per-pin enables
    logic [SHZ_PIN_N-1:0] lock_reg;      // set once an enable was written

    // external request input and flag
    logic                 ext_prev_reg;  // last sampled input level
    logic                 flag_reg;      // external request flag
    logic                 flag_seen_reg; // flag was read as one

    // registered pin and request outputs
    logic [SHZ_PIN_N-1:0] pin_reg;
    logic [SHZ_PIN_N-1:0] pin_oe_reg;
    logic                 ch0_out_reg;
    logic                 ch34_out_reg;

    // request seen, answer pending or completing
    wire req      = wb_cyc_i & wb_stb_i;
    wire lane0    = wb_sel_i[0];
    // writes and read side effects take hold at the edge that ends ack
    wire wr_fire  = req & wb_we_i & ack_reg & lane0;
    wire rd_fire  = req & ~wb_we_i & ack_reg;

    wire hit_sw   = adr_hit(wb_adr_i, SHZ_SWREQ_OFS);
    wire hit_en   = adr_hit(wb_adr_i, SHZ_PINEN_OFS);
    wire hit_flag = adr_hit(wb_adr_i, SHZ_FLAG_OFS);

    wire wr_sw    = wr_fire & hit_sw;
    wire wr_en    = wr_fire & hit_en;
    wire wr_flag  = wr_fire & hit_flag;
    wire rd_sw    = rd_fire & hit_sw;
    wire rd_flag  = rd_fire & hit_flag;

    wire wr_ch0   = wb_dat_i[SHZ_CH0_BIT];
    wire wr_ch34  = wb_dat_i[SHZ_CH34_BIT];
    wire wr_fl    = wb_dat_i[SHZ_FLAG_BIT];

    // falling edge of the active-low request input
    wire ext_fall = ext_prev_reg & ~ext_hiz_req_n_i;

    // read views: unused and reserved bits fixed at zero
    wire [7:0] sw_view   = {5'h00, 1'h0, ch0_reg, ch34_reg};
    wire [7:0] en_view   = {4'h0, en_reg};
    wire [7:0] flag_view = {7'h00, flag_reg};

    // unmapped addresses read zero and still get an answer
    wire [7:0] rd_byte = hit_sw   ? sw_view :
                         hit_en   ? en_view :
                         hit_flag ? flag_view : 8'h00;

    // clear only after the bit was read as one; a set always wins
    wire ch0_clr  = wr_sw & ~wr_ch0 & ch0_seen_reg;
    wire ch34_clr = wr_sw & ~wr_ch34 & ch34_seen_reg;
    wire ch0_next  = (wr_sw & wr_ch0) | (ch0_reg & ~ch0_clr);
    wire ch34_next = (wr_sw & wr_ch34) | (ch34_reg & ~ch34_clr);
    wire flag_next = ext_fall |
                     (flag_reg & ~(wr_flag & ~wr_fl & flag_seen_reg));

    // arming: set by a read showing one, dropped by any lane-0 write to the same register
    wire ch0_seen_next  = (rd_sw & ch0_reg) | (ch0_seen_reg & ~wr_sw);
    wire ch34_seen_next = (rd_sw & ch34_reg) | (ch34_seen_reg & ~wr_sw);
    wire flag_seen_next = (rd_flag & flag_reg) | (flag_seen_reg & ~wr_flag);

    // a locked enable ignores the write bit and keeps its value
    wire [SHZ_PIN_N-1:0] en_wmask = {SHZ_PIN_N{wr_en}} & ~lock_reg;
    wire [SHZ_PIN_N-1:0] en_next  = (en_wmask & wb_dat_i[SHZ_PIN_N-1:0]) |
                                    (~en_wmask & en_reg);
    wire [SHZ_PIN_N-1:0] lock_next = lock_reg | en_wmask;

    // per-pin gate
    shz_gate_if gate_bus ();
    assign gate_bus.flag = flag_reg;
    assign gate_bus.ch0  = ch0_reg;
    assign gate_bus.en   = en_reg;

    shz_pin_gate u_gate (
        .gi (gate_bus.gate)
    );

    // bus answer: one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'h0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            dat_reg <= {24'h00_0000, rd_byte};
        end
    end

    // software request bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch0_reg       <= SHZ_REQ_RST;
            ch34_reg      <= SHZ_REQ_RST;
            ch0_seen_reg  <= 1'h0;
            ch34_seen_reg <= 1'h0;
        end else begin
            ch0_reg       <= ch0_next;
            ch34_reg      <= ch34_next;
            ch0_seen_reg  <= ch0_seen_next;
            ch34_seen_reg <= ch34_seen_next;
        end
    end

    // write-once enables; any rst_i reset, also mid-run, reopens them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg   <= SHZ_PINEN_RST;
            lock_reg <= SHZ_LOCK_RST;
        end else begin
            en_reg   <= en_next;
            lock_reg <= lock_next;
        end
    end

    // external request detection and flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_prev_reg  <= SHZ_PIN_IDLE;
            flag_reg      <= SHZ_FLAG_RST;
            flag_seen_reg <= 1'h0;
        end else begin
            ext_prev_reg  <= ext_hiz_req_n_i;
            flag_reg      <= flag_next;
            flag_seen_reg <= flag_seen_next;
        end
    end

    // pins: registered so outputs are glitch free, at one clock of delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_reg      <= {SHZ_PIN_N{1'h0}};
            pin_oe_reg   <= {SHZ_PIN_N{1'h1}};
            ch0_out_reg  <= 1'h0;
            ch34_out_reg <= 1'h0;
        end else begin
            pin_reg      <= timer_out_i;
            pin_oe_reg   <= ~gate_bus.hiz;
            ch0_out_reg  <= ch0_reg;
            ch34_out_reg <= ch34_reg;
        end
    end

    assign wb_ack_o       = ack_reg;
    assign wb_dat_o       = dat_reg;
    assign timer_pin_o    = pin_reg;
    assign timer_pin_oe_o = pin_oe_reg;
    assign chan0_hiz_o    = ch0_out_reg;
    assign chan34_hiz_o   = ch34_out_reg;
    assign ext_flag_o     = flag_reg;

    // checks: reset values of both registers
    property p_reset_zero;
        @(posedge clk_i) rst_i |=> (!ch0_reg && !ch34_reg && en_reg == 4'h0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("registers not zero after reset");

    // reads of the request register show zero above bit 1
    property p_sw_rsv_read;
        @(posedge clk_i) disable iff (rst_i)
        (req && !ack_reg && !wb_we_i && hit_sw) |=> (wb_dat_o[7:2] == 6'h00);
    endproperty
    a_sw_rsv_read: assert property (p_sw_rsv_read)
        else $error("reserved request bits read nonzero");

    // writing one sets channel-0 request and it appears on its output
    property p_ch0_set;
        @(posedge clk_i) disable iff (rst_i)
        (wr_sw && wr_ch0) |=> ch0_reg ##1 chan0_hiz_o;
    endproperty
    a_ch0_set: assert property (p_ch0_set)
        else $error("channel-0 request not set by write one");

    // armed write of zero clears channel-0 request
    property p_ch0_clr;
        @(posedge clk_i) disable iff (rst_i)
        (wr_sw && !wr_ch0 && ch0_seen_reg) |=> !ch0_reg ##1 !chan0_hiz_o;
    endproperty
    a_ch0_clr: assert property (p_ch0_clr)
        else $error("channel-0 request not cleared");

    // an unarmed write of zero leaves a set channel-0 request alone
    property p_ch0_hold;
        @(posedge clk_i) disable iff (rst_i)
        (ch0_reg && !ch0_seen_reg && wr_sw) |=> ch0_reg;
    endproperty
    a_ch0_hold: assert property (p_ch0_hold)
        else $error("channel-0 request cleared without prior read");

    // channel 3/4 request set and output follow
    property p_ch34_set;
        @(posedge clk_i) disable iff (rst_i)
        (wr_sw && wr_ch34) |=> ch34_reg ##1 chan34_hiz_o;
    endproperty
    a_ch34_set: assert property (p_ch34_set)
        else $error("channel 3/4 request not set by write one");

    // channel 3/4 request clear after read of one
    property p_ch34_clr;
        @(posedge clk_i) disable iff (rst_i)
        (wr_sw && !wr_ch34 && ch34_seen_reg) |=> !ch34_reg;
    endproperty
    a_ch34_clr: assert property (p_ch34_clr)
        else $error("channel 3/4 request not cleared");

    // a locked enable register never changes
    property p_en_lock;
        @(posedge clk_i) disable iff (rst_i)
        (lock_reg == 4'hf) |=> $stable(en_reg);
    endproperty
    a_en_lock: assert property (p_en_lock)
        else $error("locked pin enable changed");

    // first write to the enables lands and locks them
    property p_en_first;
        @(posedge clk_i) disable iff (rst_i)
        (wr_en && lock_reg == 4'h0) |=>
            (en_reg == $past(wb_dat_i[3:0]) && lock_reg == 4'hf);
    endproperty
    a_en_first: assert property (p_en_first)
        else $error("first enable write not taken");

    // a falling input edge raises the flag, then floats enabled pins
    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        ext_fall |=> flag_reg ##1 (timer_pin_oe_o == ~$past(en_reg));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("external edge did not float enabled pins");

    // pins float exactly when enabled and a source is set
    property p_pin_float;
        @(posedge clk_i) disable iff (rst_i)
        (ch0_reg || flag_reg) |=> (timer_pin_oe_o == ~$past(en_reg));
    endproperty
    a_pin_float: assert property (p_pin_float)
        else $error("pin enable state wrong under request");

    // without any source every pin stays driven
    property p_pin_driven;
        @(posedge clk_i) disable iff (rst_i)
        (!ch0_reg && !flag_reg) |=> (timer_pin_oe_o == 4'hf);
    endproperty
    a_pin_driven: assert property (p_pin_driven)
        else $error("pin floated without request");

    // ack lasts one cycle
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

endmodule : shz_top

// ### tb/shz_far_model.sv
// Purpose: far-side model of the timer pins and external request input
// Assumes: request input idles high through an external pull-up
// Notes:   no pull on timer pins, so a floated pin shows its inverse level
`timescale 1ns/10ps
module shz_far_model
(
    input  wire logic       clk_i,
    input  wire logic [3:0] pin_drive_i,  // levels sent out by the block
    input  wire logic [3:0] pin_oe_i,     // high while the block drives
    output logic      [3:0] timer_out_o,  // timer compare levels
    output logic            req_n_o,      // external request, active low
    output logic      [3:0] pin_level_o   // resolved pin wire levels
);
    logic [3:0] last_reg;                 // last level really driven

    initial begin
        timer_out_o = 4'h0;
        req_n_o     = 1'b1;
        last_reg    = 4'h0;
    end

    // timer levels walk so that a stuck pin copy shows up
    always @(posedge clk_i) begin
        timer_out_o <= timer_out_o + 4'h3;
        for (int i = 0; i < 4; i++) begin
            if (pin_oe_i[i]) begin
                last_reg[i] <= pin_drive_i[i];
            end
        end
    end

    // a floated pin must not echo its old value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_level_o[i] = pin_oe_i[i] ? pin_drive_i[i] : ~last_reg[i];
        end
    end

    // one low pulse on the request input, falling edge is the trigger
    task automatic pulse_request(input int len);
        @(posedge clk_i);
        req_n_o <= 1'b0;
        repeat (len) @(posedge clk_i);
        req_n_o <= 1'b1;
    endtask : pulse_request
endmodule : shz_far_model

// ### tb/tb_shz_top.sv
// Purpose: self-checking bench for the software high-impedance block
// Assumes: one wishbone answer per request, pins lag registers by a clock
// Notes:   expectations come from the register rules, not from the design
`timescale 1ns/10ps
module tb_shz_top
    import shz_pkg::*;
;
    logic                 clk_i, rst_i;
    logic                 wb_cyc, wb_stb, wb_we, wb_ack, ext_req_n;
    logic [SHZ_ADR_W-1:0] wb_adr;
    logic [3:0]           wb_sel;
    logic [SHZ_DAT_W-1:0] wb_wdat, wb_rdat, rd;     // rd: last read data
    logic [SHZ_PIN_N-1:0] t_out, t_out_d, pin_o, pin_oe, pin_lvl;
    logic                 ch0_hiz, ch34_hiz, ext_flag;
    int                   n_fail, num_checks;

    shz_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .ext_hiz_req_n_i(ext_req_n),
        .timer_out_i(t_out), .timer_pin_o(pin_o), .timer_pin_oe_o(pin_oe),
        .chan0_hiz_o(ch0_hiz), .chan34_hiz_o(ch34_hiz),
        .ext_flag_o(ext_flag));

    shz_far_model far (.clk_i(clk_i), .pin_drive_i(pin_o),
        .pin_oe_i(pin_oe), .timer_out_o(t_out), .req_n_o(ext_req_n),
        .pin_level_o(pin_lvl));

    // timer level one clock back, what the pin copy should show
    always @(posedge clk_i) t_out_d <= t_out;

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
        int k;
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we} <= {2'b11, w};
        {wb_adr, wb_sel, wb_wdat} <= {a, 4'h1, 24'h0, d};
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (wb_ack === 1'b1) break;
        end
        rd = wb_rdat;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
        if (k == 20) begin
            n_fail++;
            report_and_stop();
        end
    endtask : wb

    // let register changes reach the registered pins
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic s_reset;
        settle();
        wb(1'b0, SHZ_SWREQ_OFS, 8'h00);
        chk(rd, 32'h0);
        wb(1'b0, SHZ_PINEN_OFS, 8'h00);
        chk(rd, 32'h0);
        chk(32'(pin_oe), 32'hf);
    endtask : s_reset

    // set, refused clear, armed clear for both request bits
    // software writes zero to reserved bits, so only bits 1:0 are sent
    task automatic s_swreq;
        wb(1'b1, SHZ_SWREQ_OFS, 8'h03);
        // no read since the last write: this zero must not clear
        wb(1'b1, SHZ_SWREQ_OFS, 8'h00);
        wb(1'b0, SHZ_SWREQ_OFS, 8'h00);
        chk(rd, 32'h3);
        settle();
        chk(32'({ch0_hiz, ch34_hiz}), 32'h3);
        chk(32'(pin_oe), 32'hf);
        // both bits were just read as one: a zero write clears them
        wb(1'b1, SHZ_SWREQ_OFS, 8'h00);
        wb(1'b0, SHZ_SWREQ_OFS, 8'h00);
        chk(rd, 32'h0);
        settle();
        chk(32'({ch0_hiz, ch34_hiz}), 32'h0);
        wb(1'b1, SHZ_SWREQ_OFS, 8'h02);
        wb(1'b0, SHZ_SWREQ_OFS, 8'h00);
        chk(rd, 32'h2);
        // channel-0 is armed now; writing one to it again must win
        wb(1'b1, SHZ_SWREQ_OFS, 8'h03);
        wb(1'b0, SHZ_SWREQ_OFS, 8'h00);
        chk(rd, 32'h3);
    endtask : s_swreq

    // write-once enables on pins a and c, channel-0 request still set
    task automatic s_pinen;
        wb(1'b1, SHZ_PINEN_OFS, 8'h05);
        wb(1'b1, SHZ_PINEN_OFS, 8'h0a);
        wb(1'b0, SHZ_PINEN_OFS, 8'h00);
        chk(rd, 32'h5);
        settle();
        chk(32'(pin_oe), 32'ha);
        chk(32'(pin_o), 32'(t_out_d));
        // driven pins carry the timer level onto the wire
        chk(32'(pin_lvl & pin_oe), 32'(t_out_d & pin_oe));
        wb(1'b0, SHZ_SWREQ_OFS, 8'h00);
        wb(1'b1, SHZ_SWREQ_OFS, 8'h00);
        settle();
        chk(32'(pin_oe), 32'hf);
    endtask : s_pinen

    // external request floats enabled pins until the flag is cleared
    task automatic s_flag;
        far.pulse_request(2);
        settle();
        chk(32'(ext_flag), 32'h1);
        chk(32'(pin_oe), 32'ha);
        wb(1'b0, SHZ_FLAG_OFS, 8'h00);
        chk(rd, 32'h1);
        wb(1'b1, SHZ_FLAG_OFS, 8'h00);
        settle();
        chk(32'(pin_oe), 32'hf);
        wb(1'b1, 4'hc, 8'hff);
        wb(1'b0, 4'hc, 8'h00);
        chk(rd, 32'h0);
    endtask : s_flag

    // reset in mid-run: request bit zero again, enable locks reopened
    task automatic s_rerun;
        wb(1'b1, SHZ_SWREQ_OFS, 8'h02);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, SHZ_SWREQ_OFS, 8'h00);
        chk(rd, 32'h0);
        wb(1'b0, SHZ_PINEN_OFS, 8'h00);
        chk(rd, 32'h0);
        wb(1'b1, SHZ_PINEN_OFS, 8'h0a);
        wb(1'b1, SHZ_PINEN_OFS, 8'h05);
        wb(1'b0, SHZ_PINEN_OFS, 8'h00);
        chk(rd, 32'ha);
        settle();
        chk(32'(ch0_hiz), 32'h0);
    endtask : s_rerun

    initial begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we} = 3'b000;
        {wb_adr, wb_sel, wb_wdat} = '0;
        n_fail = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        s_reset();
        s_swreq();
        s_pinen();
        s_flag();
        s_rerun();
        report_and_stop();
    end
endmodule : tb_shz_top
